// ===== hw/cfi_pkg.sv
// Package with register map, field layout and reset values of the converter fault block.
package cfi_pkg;

    // Number of monitored converters and LDO regulators.
    localparam int unsigned CFI_NCONV = 4;
    localparam int unsigned CFI_NLDO  = 4;

    // Width of a voltage measurement or target code.
    localparam int unsigned CFI_VW = 10;

    // Under-voltage threshold as a percentage of the target level.
    localparam logic [6:0] CFI_UV_PCT  = 7'd95;
    localparam logic [6:0] CFI_PCT_ALL = 7'd100;

    // Converter two carries no over-current source.
    localparam int unsigned CFI_NO_OC_CONV = 1;

    // Register indexes; the byte address is four times the index.
    localparam logic [11:0] CFI_IDX_UV_STATUS  = 12'h01C;
    localparam logic [11:0] CFI_IDX_UV_MASK    = 12'h024;
    localparam logic [11:0] CFI_IDX_FAULT_MASK = 12'h0D7;
    localparam logic [11:0] CFI_IDX_EVT_STATUS = 12'h0E0;
    localparam logic [11:0] CFI_IDX_EVT_MASK   = 12'h0E1;
    localparam logic [11:0] CFI_IDX_CTRL       = 12'h0E2;

    // Width of the register data held by the documented registers.
    localparam int unsigned CFI_RW = 16;

    // Reset values.
    localparam logic [3:0] CFI_RST_UV_MASK    = 4'h0;
    localparam logic [3:0] CFI_RST_FAULT_MASK = 4'h0;
    localparam logic [2:0] CFI_RST_EVT_MASK   = 3'h0;
    localparam logic       CFI_RST_PIN_ENA    = 1'b0;

    // Event status bit positions.
    localparam int unsigned CFI_EVT_FAULT_SET = 0;
    localparam int unsigned CFI_EVT_UVIRQ_SET = 1;
    localparam int unsigned CFI_EVT_FAULT_CLR = 2;
    localparam int unsigned CFI_NEVT          = 3;

    // Control register bit: general-purpose pin works as the fault output.
    localparam int unsigned CFI_CTRL_PIN_ENA = 0;

    // AXI responses.
    localparam logic [1:0] CFI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CFI_RESP_SLVERR = 2'h2;

endpackage

// ===== hw/cfi_sync2.sv
// Two flip-flop synchroniser for a group of independent level inputs.
`timescale 1ns/10ps
module cfi_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta;

    // Each bit is an independent level, so per-bit sampling is safe.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// ===== hw/cfi_fault_irq.sv
// Converter under-voltage interrupt collector and active-low fault pin driver.
//
// How it works
// - per-converter sticky rising-edge flag, cleared on read
// - mask bit one blocks flag from interrupt
// - configured fault pin low on any unmasked fault
// - fault-pin mask bits three..zero for converters
// - fault-pin mask zero passes, one blocks
// - unmasked under/over-voltage pulls pin low
// - converter two has no over-current source
// - fault-pin mask bits three, two reset zero
// - under-voltage below ninety-five percent of target
// - first-level interrupt also merges LDO interrupts
`timescale 1ns/10ps
module cfi_fault_irq
    import cfi_pkg::*;
(
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_i,
    // AXI4-Lite slave.
    input  wire logic [13:0]                s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic [1:0]                      s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [13:0]                s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic [31:0]                     s_axi_rdata_o,
    output logic [1:0]                      s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i,
    // Converter measurements and targets from on-chip logic, same clock.
    input  wire logic [CFI_NCONV*CFI_VW-1:0] conv_meas_i,
    input  wire logic [CFI_NCONV*CFI_VW-1:0] conv_target_i,
    // Fault sources from the analog side, asynchronous levels.
    input  wire logic [CFI_NCONV-1:0]       conv_ov_i,
    input  wire logic [CFI_NCONV-1:0]       conv_oc_i,
    input  wire logic [CFI_NLDO-1:0]        ldo_fault_i,
    input  wire logic                       climit_fault_i,
    input  wire logic [CFI_NLDO-1:0]        ldo_uv_irq_i,
    // First-level under-voltage interrupt and block interrupt.
    output logic                            supply_undervolt_irq_o,
    output logic                            irq_o,
    // Fault pin, active low, with its output enable.
    output logic                            fault_pin_n_o,
    output logic                            fault_pin_oe_o
);

    // Synchronised copies of the asynchronous inputs.
    logic [CFI_NCONV-1:0] ov_s;         // Over-voltage per converter.
    logic [CFI_NCONV-1:0] oc_s;         // Over-current per converter.
    logic [CFI_NLDO-1:0]  ldo_f_s;      // LDO fault levels.
    logic                 clim_s;       // Current limit switch fault.
    logic [CFI_NLDO-1:0]  ldo_uv_s;     // LDO second-level interrupts.

    // Under-voltage state per converter.
    logic [CFI_NCONV-1:0] uv_calc;      // Comparator result, combinational.
    logic [CFI_NCONV-1:0] uv_cond;      // Registered under-voltage condition.
    logic [CFI_NCONV-1:0] uv_prev;      // Previous condition for edge detect.
    logic [CFI_NCONV-1:0] uv_rise;      // Rising edge of the condition.
    logic [CFI_NCONV-1:0] conv_fault;   // Combined fault per converter.

    // Software visible registers.
    logic [CFI_NCONV-1:0] uv_status;    // Sticky under-voltage flags.
    logic [CFI_NCONV-1:0] uv_mask;      // Interrupt mask, one blocks.
    logic [CFI_NCONV-1:0] fault_mask;   // Fault pin mask, one blocks.
    logic [CFI_NEVT-1:0]  evt_status;   // Sticky block events.
    logic [CFI_NEVT-1:0]  evt_mask;     // Event enables, one passes.
    logic                 pin_ena;      // Pin configured as fault output.

    // Bus channel state.
    logic [11:0]          aw_idx;       // Latched write index.
    logic                 aw_got;       // Write address held.
    logic [31:0]          w_data;       // Latched write data.
    logic [3:0]           w_strb;       // Latched byte strobes.
    logic                 w_got;        // Write data held.
    logic                 wr_fire;      // One-cycle write commit.
    logic                 rd_fire;      // Read address handshake.
    logic [11:0]          ar_idx;       // Index of the read request.
    logic                 rd_clear;     // Status register is being read.

    // Fault aggregation and its history.
    logic                 fault_any;    // Any enabled fault source active.
    logic                 fault_prev;   // Previous fault_any.
    logic                 uvirq_any;    // Next first-level interrupt level.
    logic [CFI_NEVT-1:0]  evt_set;      // Event pulses this cycle.

    // Analog levels cross into the clock domain through two flops.
    cfi_sync2 #(
        .WIDTH (2*CFI_NCONV + 2*CFI_NLDO + 1)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   ({conv_ov_i, conv_oc_i, ldo_fault_i, climit_fault_i, ldo_uv_irq_i}),
        .sync_o    ({ov_s, oc_s, ldo_f_s, clim_s, ldo_uv_s})
    );

    // Per-converter comparator and fault merge.
    for (genvar gi = 0; gi < CFI_NCONV; gi++) begin : g_conv
        logic [16:0] meas_scaled;   // Measurement times one hundred.
        logic [16:0] targ_scaled;   // Target times ninety-five.
        // Integer scaling avoids a divider and keeps the 95 % figure exact.
        assign meas_scaled = 17'(conv_meas_i[gi*CFI_VW +: CFI_VW] * CFI_PCT_ALL);
        assign targ_scaled = 17'(conv_target_i[gi*CFI_VW +: CFI_VW] * CFI_UV_PCT);
        assign uv_calc[gi] = (meas_scaled < targ_scaled);
        if (gi == CFI_NO_OC_CONV) begin : g_no_oc
            // Only voltage conditions count; the over-current input is ignored.
            assign conv_fault[gi] = uv_cond[gi] | ov_s[gi];
        end else begin : g_oc
            assign conv_fault[gi] = uv_cond[gi] | ov_s[gi] | oc_s[gi];
        end
    end

    // The comparator result is registered once, then kept for edge detection.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_cond <= '0;
            uv_prev <= '0;
        end else begin
            uv_cond <= uv_calc;
            uv_prev <= uv_cond;
        end
    end

    // Only a new under-voltage raises a flag; a steady one does not re-arm it.
    assign uv_rise = uv_cond & ~uv_prev;

    // Fault output term: masked converters drop out, LDOs and switch always count.
    assign fault_any = (|(conv_fault & ~fault_mask)) | (|ldo_f_s) | clim_s;

    // First-level interrupt term from flags, mask and LDO interrupts.
    assign uvirq_any = (|(uv_status & ~uv_mask)) | (|ldo_uv_s);

    // Bus handshakes.
    assign wr_fire  = aw_got & w_got & ~s_axi_bvalid_o;
    assign rd_fire  = s_axi_arvalid_i & s_axi_arready_o;
    assign ar_idx   = s_axi_araddr_i[13:2];
    assign rd_clear = rd_fire & (ar_idx == CFI_IDX_UV_STATUS);

    // Write address channel; one write is handled at a time.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b0;
            aw_got          <= 1'b0;
            aw_idx          <= 12'h000;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            aw_got          <= 1'b0;
            s_axi_awready_o <= 1'b1;
        end else if (s_axi_awready_o && s_axi_awvalid_i) begin
            aw_got          <= 1'b1;
            aw_idx          <= s_axi_awaddr_i[13:2];
            s_axi_awready_o <= 1'b0;
        end else if (!aw_got) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    // Write data channel, independent of the address channel.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_wready_o <= 1'b0;
            w_got          <= 1'b0;
            w_data         <= 32'h0000_0000;
            w_strb         <= 4'h0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            w_got          <= 1'b0;
            s_axi_wready_o <= 1'b1;
        end else if (s_axi_wready_o && s_axi_wvalid_i) begin
            w_got          <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (!w_got) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    // Write response follows the commit by one cycle.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= CFI_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            // The under-voltage status register is read-only; a write there is an error.
            case (aw_idx)
                CFI_IDX_UV_MASK,
                CFI_IDX_FAULT_MASK,
                CFI_IDX_EVT_STATUS,
                CFI_IDX_EVT_MASK,
                CFI_IDX_CTRL:       s_axi_bresp_o <= CFI_RESP_OKAY;
                default:            s_axi_bresp_o <= CFI_RESP_SLVERR;
            endcase
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read channel; the data are taken at the address handshake.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= CFI_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rresp_o   <= CFI_RESP_OKAY;
            // Unused upper bits read as zero.
            case (ar_idx)
                CFI_IDX_UV_STATUS:  s_axi_rdata_o <= {28'h0, uv_status};
                CFI_IDX_UV_MASK:    s_axi_rdata_o <= {28'h0, uv_mask};
                CFI_IDX_FAULT_MASK: s_axi_rdata_o <= {28'h0, fault_mask};
                CFI_IDX_EVT_STATUS: s_axi_rdata_o <= {29'h0, evt_status};
                CFI_IDX_EVT_MASK:   s_axi_rdata_o <= {29'h0, evt_mask};
                CFI_IDX_CTRL:       s_axi_rdata_o <= {31'h0, pin_ena};
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= CFI_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end else if (!s_axi_rvalid_o) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    // Under-voltage flags: a read clears them, a new edge in the same cycle wins.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_status <= '0;
        end else begin
            uv_status <= (uv_status & ~{CFI_NCONV{rd_clear}}) | uv_rise;
        end
    end

    // Writable configuration; only byte lane zero holds meaningful bits.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_mask    <= CFI_RST_UV_MASK;
            fault_mask <= CFI_RST_FAULT_MASK;
            evt_mask   <= CFI_RST_EVT_MASK;
            pin_ena    <= CFI_RST_PIN_ENA;
        end else if (wr_fire && w_strb[0]) begin
            case (aw_idx)
                CFI_IDX_UV_MASK:    uv_mask    <= w_data[CFI_NCONV-1:0];
                CFI_IDX_FAULT_MASK: fault_mask <= w_data[CFI_NCONV-1:0];
                CFI_IDX_EVT_MASK:   evt_mask   <= w_data[CFI_NEVT-1:0];
                CFI_IDX_CTRL:       pin_ena    <= w_data[CFI_CTRL_PIN_ENA];
                default: begin
                    // Other indexes hold no configuration.
                end
            endcase
        end
    end

    // Event pulses for the block interrupt.
    always_comb begin
        evt_set                    = '0;
        evt_set[CFI_EVT_FAULT_SET] = fault_any & ~fault_prev;
        evt_set[CFI_EVT_UVIRQ_SET] = uvirq_any & ~supply_undervolt_irq_o;
        evt_set[CFI_EVT_FAULT_CLR] = ~fault_any & fault_prev;
    end

    // Event flags clear by writing one; an event in the same cycle survives.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_status <= '0;
            fault_prev <= 1'b0;
        end else begin
            fault_prev <= fault_any;
            if (wr_fire && w_strb[0] && aw_idx == CFI_IDX_EVT_STATUS) begin
                evt_status <= (evt_status & ~w_data[CFI_NEVT-1:0]) | evt_set;
            end else begin
                evt_status <= evt_status | evt_set;
            end
        end
    end

    // Interrupt outputs are registered so no glitch reaches the pins.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            supply_undervolt_irq_o <= 1'b0;
            irq_o                  <= 1'b0;
        end else begin
            supply_undervolt_irq_o <= uvirq_any;
            irq_o                  <= |(evt_status & evt_mask);
        end
    end

    // Fault pin: driven only while configured, released high otherwise.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_pin_n_o  <= 1'b1;
            fault_pin_oe_o <= 1'b0;
        end else begin
            fault_pin_oe_o <= pin_ena;
            fault_pin_n_o  <= ~(pin_ena & fault_any);
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_uv_flag_set: assert property (
        |uv_rise |=> ((uv_status & $past(uv_rise)) == $past(uv_rise)))
        else $error("Under-voltage edge did not set its flag.");

    a_uv_read_clr: assert property (
        rd_clear && !(|uv_rise) |=> (uv_status == '0) && (s_axi_rdata_o[3:0] == $past(uv_status)))
        else $error("Status read did not return and clear the flags.");

    a_uv_mask_block: assert property (
        (uv_status != '0) && ((uv_status & ~uv_mask) == '0) && !(|ldo_uv_s)
        |=> !supply_undervolt_irq_o)
        else $error("Masked flag raised the first-level interrupt.");

    a_pin_low_fault: assert property (
        pin_ena && (|ldo_f_s || clim_s) |=> !fault_pin_n_o && fault_pin_oe_o)
        else $error("Fault pin not low on regulator or switch fault.");

    a_fmask_read: assert property (
        rd_fire && ar_idx == CFI_IDX_FAULT_MASK |=> s_axi_rdata_o == {28'h0, $past(fault_mask)})
        else $error("Fault mask read back wrong.");

    a_pin_mask_pass: assert property (
        pin_ena && !(|ldo_f_s) && !clim_s && ((conv_fault & ~fault_mask) == '0)
        |=> fault_pin_n_o)
        else $error("Masked converter fault drove the pin low.");

    a_pin_uv_ov: assert property (
        pin_ena && (|((uv_cond | ov_s) & ~fault_mask)) |=> !fault_pin_n_o)
        else $error("Unmasked voltage fault left the pin high.");

    a_conv2_no_oc: assert property (
        pin_ena && oc_s[1] && !uv_cond[1] && !ov_s[1] && !(|ldo_f_s) && !clim_s
        && ((conv_fault & ~fault_mask & 4'hD) == '0) |=> fault_pin_n_o)
        else $error("Converter two over-current reached the pin.");

    a_fmask_reset: assert property (
        $fell(rst_i) |-> fault_mask[3:2] == 2'h0)
        else $error("Fault mask upper bits not zero after reset.");

    a_uv_threshold: assert property (
        (conv_meas_i[9:0] * 100 < conv_target_i[9:0] * 95) |=> uv_cond[0])
        else $error("Under-voltage not flagged below threshold.");

    a_ldo_irq_merge: assert property (
        |ldo_uv_s |=> supply_undervolt_irq_o)
        else $error("LDO interrupt did not reach first-level interrupt.");

    a_uv_irq_level: assert property (
        |(uv_status & ~uv_mask) |=> supply_undervolt_irq_o)
        else $error("Unmasked flag did not raise the first-level interrupt.");

endmodule

// ===== testbench/cfi_pin_pullup.sv
// Board side of the fault pin: a pull-up resistor and the external logic reading it.
`timescale 1ns/10ps
module cfi_pin_pullup (
    input  wire logic pin_n_i,
    input  wire logic pin_oe_i,
    output logic      level_o
);
    // The wire follows the block only while it drives; otherwise the pull-up wins.
    // Reading the pull-up level keeps a released pin from passing for a driven low.
    always_comb begin
        level_o = pin_oe_i ? pin_n_i : 1'b1;
    end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the converter fault interrupt and fault pin block.
`timescale 1ns/10ps
module tb_top;
    import cfi_pkg::*;
    logic        clk = 1'b0;          // System clock, 200 MHz.
    logic        rst = 1'b1;          // Asynchronous reset, active high.
    logic [13:0] awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, uv_irq, irq, pin_n, pin_oe, level;
    logic [1:0]  bresp, rresp, resp;
    logic [39:0] meas = {4{10'h064}};  // All converters sit at target.
    logic [39:0] targ = {4{10'h064}};  // Target codes, one per converter.
    logic [3:0]  ov = '0, oc = '0, ldo_f = '0, ldo_uv = '0;
    logic        climit = 1'b0;
    logic [31:0] rd;
    int          errors = 0;
    int          samples_checked = 0;
    always #2.5 clk = ~clk;
    cfi_fault_irq cfi_fault_irq_i (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .conv_meas_i(meas), .conv_target_i(targ),
        .conv_ov_i(ov), .conv_oc_i(oc), .ldo_fault_i(ldo_f), .climit_fault_i(climit),
        .ldo_uv_irq_i(ldo_uv), .supply_undervolt_irq_o(uv_irq), .irq_o(irq),
        .fault_pin_n_o(pin_n), .fault_pin_oe_o(pin_oe));
    cfi_pin_pullup cfi_pin_pullup_i (.pin_n_i(pin_n), .pin_oe_i(pin_oe), .level_o(level));
    // Prints the verdict; the only place where the run ends.
    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Compares one observed value with its expectation.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Write: both channels offered together; handshakes judged from values settled mid-cycle.
    task automatic wr(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
        int  n;
        logic aw_hs, w_hs, b_hs;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            aw_hs = awvalid && (awready === 1'b1);
            w_hs = wvalid && (wready === 1'b1);
            b_hs = bvalid === 1'b1;
            r = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            chk(0, 1, "write timeout");
            final_report();
        end
    endtask
    // Read: address held until taken, rready held until the data are sampled.
    task automatic rdr(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
        int  n;
        logic ar_hs, r_hs;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ar_hs = arvalid && (arready === 1'b1);
            r_hs = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            chk(0, 1, "read timeout");
            final_report();
        end
    endtask
    // Puts the converters flagged in m below ninety-five percent of target.
    task automatic set_uv(input logic [3:0] m);
        @(posedge clk);
        for (int i = 0; i < 4; i++) meas[i*10+:10] <= m[i] ? 10'h05A : 10'h064;
    endtask
    // Reset values, an unmapped read and a refused write to the read-only status.
    task automatic t_reset();
        chk(level, 1, "idle pin");
        rdr(CFI_IDX_FAULT_MASK, rd, resp);
        chk(rd, 0, "fault mask reset");
        chk(resp, CFI_RESP_OKAY, "read response");
        rdr(CFI_IDX_UV_MASK, rd, resp);
        chk(rd, 0, "uv mask reset");
        rdr(12'hFFF, rd, resp);
        chk(rd, 32'h0, "unmapped read data");
        chk(resp, CFI_RESP_SLVERR, "unmapped read response");
        wr(CFI_IDX_UV_STATUS, 32'hF, resp);
        chk(resp, CFI_RESP_SLVERR, "status write");
        $display("test reset done");
    endtask
    // Edge-set flags, cleared by the read; a lasting condition does not set again.
    task automatic t_uv();
        set_uv(4'h9);
        cyc(5);
        chk(uv_irq, 1, "uv irq on");
        rdr(CFI_IDX_UV_STATUS, rd, resp);
        chk(rd, 32'h9, "uv status");
        rdr(CFI_IDX_UV_STATUS, rd, resp);
        chk(rd, 0, "uv status after read");
        cyc(3);
        chk(uv_irq, 0, "uv irq off");
        set_uv(4'h0);
        wr(CFI_IDX_UV_MASK, 32'h1, resp);
        set_uv(4'h1);
        cyc(5);
        chk(uv_irq, 0, "masked flag");
        rdr(CFI_IDX_UV_STATUS, rd, resp);
        chk(rd, 32'h1, "masked flag kept");
        set_uv(4'h0);
        wr(CFI_IDX_UV_MASK, 32'h0, resp);
        ldo_uv <= 4'h2;
        cyc(5);
        chk(uv_irq, 1, "regulator irq merged");
        ldo_uv <= 4'h0;
        cyc(5);
        chk(uv_irq, 0, "regulator irq gone");
        // Exactly ninety-five percent of target is not yet an under-voltage.
        meas[19:10] <= 10'h05F;
        cyc(5);
        chk(uv_irq, 0, "at threshold");
        // Raising the target moves the same measurement below the threshold.
        targ[19:10] <= 10'h066;
        cyc(5);
        chk(uv_irq, 1, "target raised");
        rdr(CFI_IDX_UV_STATUS, rd, resp);
        chk(rd, 32'h2, "conv two flag");
        meas[19:10] <= 10'h064;
        targ[19:10] <= 10'h064;
        $display("test uv done");
    endtask
    // Fault pin sources, per-converter masking and converter two without over-current.
    task automatic t_pin();
        wr(CFI_IDX_CTRL, 32'h1, resp);
        chk(resp, CFI_RESP_OKAY, "write response");
        cyc(5);
        chk({pin_oe, level}, 2'b11, "pin enabled idle");
        ov <= 4'h4;
        cyc(5);
        chk(level, 0, "over-voltage pulls low");
        wr(CFI_IDX_FAULT_MASK, 32'h4, resp);
        cyc(5);
        chk(level, 1, "masked converter");
        rdr(CFI_IDX_FAULT_MASK, rd, resp);
        chk(rd, 32'h4, "fault mask read back");
        ov <= 4'h0;
        wr(CFI_IDX_FAULT_MASK, 32'h0, resp);
        set_uv(4'h8);
        cyc(5);
        chk(level, 0, "under-voltage pulls low");
        set_uv(4'h0);
        oc <= 4'h2;
        cyc(5);
        chk(level, 1, "conv two over-current ignored");
        oc <= 4'h1;
        cyc(5);
        chk(level, 0, "conv one over-current");
        oc <= 4'h0;
        ldo_f <= 4'h8;
        cyc(5);
        chk(level, 0, "regulator fault");
        ldo_f <= 4'h0;
        climit <= 1'b1;
        cyc(5);
        chk(level, 0, "switch fault");
        climit <= 1'b0;
        cyc(5);
        chk(level, 1, "fault gone");
        $display("test pin done");
    endtask
    // Event interrupt: raised while masked off, enabled, then cleared by writing ones.
    task automatic t_irq();
        ov <= 4'h1;
        cyc(6);
        chk(irq, 0, "event masked");
        wr(CFI_IDX_EVT_MASK, 32'h1, resp);
        cyc(3);
        chk(irq, 1, "event enabled");
        ov <= 4'h0;
        cyc(6);
        wr(CFI_IDX_EVT_STATUS, 32'h7, resp);
        cyc(3);
        chk(irq, 0, "event cleared");
        rdr(CFI_IDX_EVT_STATUS, rd, resp);
        chk(rd, 0, "event status clear");
        $display("test irq done");
    endtask
    initial begin
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_uv();
        t_pin();
        t_irq();
        final_report();
    end
endmodule
